// *** verilog/ftsr_pkg.sv ***
// Constants and types shared by the late-write burst SRAM core
`default_nettype none

package ftsr_pkg;
	// Geometry of the storage array
	localparam int ADDR_W  = 20;
	localparam int LANES   = 2;
	localparam int LANE_W  = 9;
	localparam int WORD_W  = 18;
	localparam int BURST_W = 2;

	// Burst counter start value and step
	localparam logic [BURST_W-1:0] BURST_START = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;

	// Direction input levels during a load cycle
	localparam logic DIR_READ  = 1'b1;
	localparam logic DIR_WRITE = 1'b0;

	// Burst order select levels
	localparam logic ORDER_LINEAR = 1'b0;

	// Advance-or-load input levels
	localparam logic ADV_LOAD = 1'b0;

	// Burst state, Gray coded along idle, read, write
	typedef enum logic [1:0] {
		FTSR_IDLE  = 2'b00,
		FTSR_READ  = 2'b01,
		FTSR_WRITE = 2'b11
	} ftsr_state_t;
endpackage : ftsr_pkg

`default_nettype wire

// *** verilog/ftsr_array.sv ***
// Storage array with per-lane write and a registered read port
`default_nettype none

module ftsr_array #(
	parameter int ADDR_W = 20,
	parameter int LANES  = 2,
	parameter int LANE_W = 9
) (
	input  wire logic                      clk,
	input  wire logic                      rd_en,
	input  wire logic [ADDR_W-1:0]         rd_addr,
	output logic      [LANES*LANE_W-1:0]   rd_data,
	input  wire logic [ADDR_W-1:0]         wr_addr,
	input  wire logic [LANES-1:0]          wr_lane_en,
	input  wire logic [LANES*LANE_W-1:0]   wr_data
);
	logic [LANE_W-1:0] mem_q [LANES][2**ADDR_W];
	logic [LANE_W-1:0] rd_q  [LANES];

	// One write port and one read port per byte lane
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		logic hit;
		assign hit = wr_lane_en[g] && (wr_addr == rd_addr);
		always_ff @(posedge clk) begin
			if (wr_lane_en[g]) begin
				mem_q[g][wr_addr] <= wr_data[g*LANE_W +: LANE_W];
			end
			// Bypass so a read right after a write sees the new byte
			if (rd_en) begin
				rd_q[g] <= hit ? wr_data[g*LANE_W +: LANE_W] : mem_q[g][rd_addr];
			end
		end
		assign rd_data[g*LANE_W +: LANE_W] = rd_q[g];
	end
endmodule // ftsr_array

`default_nettype wire

// *** verilog/ftsr_core.sv ***
// Flow-through late-write burst SRAM core with burst counter and output control
`default_nettype none

module ftsr_core
	import ftsr_pkg::*;
#(
	parameter int ADDR_W = ftsr_pkg::ADDR_W,
	parameter int LANES  = ftsr_pkg::LANES,
	parameter int LANE_W = ftsr_pkg::LANE_W
) (
	input  wire logic                             clk,
	input  wire logic                             srst,
	input  wire logic                             clock_hold_n,
	input  wire logic                             chip_sel_a_n,
	input  wire logic                             chip_sel_b,
	input  wire logic                             chip_sel_c_n,
	input  wire logic                             advance_or_load,
	input  wire logic                             read_write_n,
	input  wire logic [ADDR_W-1:0]                addr,
	input  wire logic [LANES-1:0]                 byte_lane_write_n,
	input  wire logic                             output_enable_n,
	input  wire logic                             linear_order_sel_n,
	input  wire logic                             sleep_request,
	input  wire logic [LANES*LANE_W-1:0]          dq_in,
	output logic      [LANES*LANE_W-1:0]          dq_out,
	output logic                                  dq_oe
);
	import ftsr_pkg::*;

	// Shape checks the logic depends on
	if (LANES * LANE_W != ftsr_pkg::WORD_W) begin : g_bad_word
		$error("ftsr_core: lanes times lane width must equal word width");
	end
	if (ADDR_W <= ftsr_pkg::BURST_W) begin : g_bad_addr
		$error("ftsr_core: address must be wider than the burst counter");
	end

	ftsr_state_t                  st_q, st_d;
	logic [ADDR_W-1:0]            base_q, base_d;
	logic [BURST_W-1:0]           cnt_q, cnt_d;
	logic                         drive_q, drive_d;
	logic                         pend_q, pend_d;
	logic [ADDR_W-1:0]            waddr_q, waddr_d;
	logic [LANES-1:0]             wbe_q, wbe_d;

	logic                         run;
	logic                         step;
	logic                         load;
	logic                         sel;
	logic                         cmd_valid;
	logic                         cmd_read;
	logic [BURST_W-1:0]           next_cnt;
	logic [BURST_W-1:0]           burst_lo;
	logic [ADDR_W-1:0]            cmd_addr;
	logic [LANES-1:0]             wr_lanes;
	logic                         rd_fire;

	// Edge qualifiers: hold masks the edge, sleep blocks new work
	assign run  = !clock_hold_n;
	assign step = run && !sleep_request;
	assign load = (advance_or_load == ADV_LOAD);
	// Selects only matter in load cycles
	assign sel  = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;

	// Burst address from start bits and count in the chosen order
	assign next_cnt = cnt_q + BURST_STEP;
	always_comb begin
		if (linear_order_sel_n == ORDER_LINEAR) begin
			burst_lo = base_q[BURST_W-1:0] + next_cnt;
		end else begin
			burst_lo = base_q[BURST_W-1:0] ^ next_cnt;
		end
	end

	// Command of this edge: a load from the pins or a burst continuation
	always_comb begin
		if (load) begin
			cmd_valid = sel;
			cmd_read  = (read_write_n == DIR_READ);
			cmd_addr  = addr;
		end else begin
			cmd_valid = (st_q != FTSR_IDLE);
			cmd_read  = (st_q == FTSR_READ);
			cmd_addr  = {base_q[ADDR_W-1:BURST_W], burst_lo};
		end
	end

	// Burst state and counter next values
	always_comb begin
		st_d   = st_q;
		base_d = base_q;
		cnt_d  = cnt_q;
		if (step) begin
			if (load) begin
				if (sel) begin
					st_d   = (read_write_n == DIR_READ) ? FTSR_READ : FTSR_WRITE;
					base_d = addr;
					cnt_d  = BURST_START;
				end else begin
					st_d = FTSR_IDLE;
				end
			end else if (st_q != FTSR_IDLE) begin
				cnt_d = next_cnt;
			end
		end
	end

	// Burst state registers
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q   <= FTSR_IDLE;
			base_q <= '0;
			cnt_q  <= BURST_START;
		end else begin
			st_q   <= st_d;
			base_q <= base_d;
			cnt_q  <= cnt_d;
		end
	end

	// Late write: the pending write lands on the next unheld edge
	assign wr_lanes = (pend_q && run) ? wbe_q : '0;
	assign rd_fire  = step && cmd_valid && cmd_read;

	// Data-path next values: pending write and output drive
	always_comb begin
		drive_d = drive_q;
		pend_d  = pend_q;
		waddr_d = waddr_q;
		wbe_d   = wbe_q;
		if (run) begin
			pend_d  = 1'b0;
			drive_d = 1'b0;
			if (step && cmd_valid) begin
				if (cmd_read) begin
					drive_d = 1'b1;
				end else begin
					pend_d  = 1'b1;
					waddr_d = cmd_addr;
					wbe_d   = ~byte_lane_write_n;
				end
			end
		end
	end

	// Data-path registers; held edges keep everything
	always_ff @(posedge clk) begin
		if (srst) begin
			drive_q <= 1'b0;
			pend_q  <= 1'b0;
			waddr_q <= '0;
			wbe_q   <= '0;
		end else begin
			drive_q <= drive_d;
			pend_q  <= pend_d;
			waddr_q <= waddr_d;
			wbe_q   <= wbe_d;
		end
	end

	// Output enable gates the pins without the clock
	assign dq_oe = drive_q && !output_enable_n;

	// Storage, one word per address, two byte lanes
	ftsr_array #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES),
		.LANE_W (LANE_W)
	) u_array (
		.clk        (clk),
		.rd_en      (rd_fire),
		.rd_addr    (cmd_addr),
		.rd_data    (dq_out),
		.wr_addr    (waddr_q),
		.wr_lane_en (wr_lanes),
		.wr_data    (dq_in)
	);

	// Checks on burst control and output timing
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_hold_freezes_burst: assert property (
		!run |=> $stable(st_q) && $stable(base_q) && $stable(cnt_q) && $stable(drive_q))
		else $error("held edge changed burst state");

	a_hold_no_write: assert property (
		!run |-> wr_lanes == '0)
		else $error("write happened on a held edge");

	a_write_data_late: assert property (
		step && cmd_valid && !cmd_read ##1 run |-> pend_q && wr_lanes == wbe_q
		&& waddr_q == $past(cmd_addr, 1))
		else $error("late write did not land one edge after command");

	a_read_drives_next: assert property (
		step && cmd_valid && cmd_read |=> drive_q)
		else $error("read data not driven in the following cycle");

	a_write_no_drive: assert property (
		run && step && cmd_valid && !cmd_read |=> !dq_oe)
		else $error("pins driven during a write cycle");

	a_desel_high_z: assert property (
		run && load && !sel |=> !dq_oe)
		else $error("pins driven after a deselect");

	a_oe_async_off: assert property (
		output_enable_n |-> !dq_oe)
		else $error("pins driven with output enable inactive");

	a_load_captures: assert property (
		step && load && sel |=> base_q == $past(addr, 1) && cnt_q == BURST_START)
		else $error("load did not capture address");

	a_burst_steps: assert property (
		step && !load && st_q != FTSR_IDLE |=> cnt_q == $past(next_cnt, 1)
		&& $stable(st_q) && $stable(base_q))
		else $error("burst counter did not step or op changed");

	a_lane_mask: assert property (
		step && cmd_valid && !cmd_read && byte_lane_write_n == '1 ##1 run |-> wr_lanes == '0)
		else $error("write abort still wrote a lane");

	// Lane, order, sleep and mixed-traffic checks
	a_lanes_sampled: assert property (
		step && cmd_valid && !cmd_read |=> wbe_q == ~$past(byte_lane_write_n, 1))
		else $error("byte lanes not taken with the write command");

	a_no_pend_no_write: assert property (
		!pend_q |-> wr_lanes == '0)
		else $error("array written with no write pending");

	a_mixed_no_gap: assert property (
		step && cmd_valid && cmd_read ##1 step && cmd_valid && !cmd_read |=> pend_q && !drive_q)
		else $error("write right after a read was not taken");

	a_advance_keeps_base: assert property (
		step && !load |=> $stable(base_q))
		else $error("advance cycle changed the burst start");

	a_desel_goes_idle: assert property (
		step && load && !sel |=> st_q == FTSR_IDLE)
		else $error("deselected load left a burst open");

	a_burst_wraps: assert property (
		step && load && sel ##1 (step && !load) [*4] |=> cnt_q == BURST_START)
		else $error("burst counter did not wrap after four steps");

	a_linear_next: assert property (
		!load && st_q != FTSR_IDLE && linear_order_sel_n == ORDER_LINEAR
		|-> cmd_addr[BURST_W-1:0] == BURST_W'(base_q[BURST_W-1:0] + cnt_q + BURST_STEP))
		else $error("linear burst address wrong");

	a_interleave_next: assert property (
		!load && st_q != FTSR_IDLE && linear_order_sel_n != ORDER_LINEAR
		|-> cmd_addr[BURST_W-1:0] == (base_q[BURST_W-1:0] ^ BURST_W'(cnt_q + BURST_STEP)))
		else $error("interleaved burst address wrong");

	a_read_oe_drives: assert property (
		step && cmd_valid && cmd_read |=> dq_oe || output_enable_n)
		else $error("read not driven with output enable active");

	a_sleep_drops_drive: assert property (
		run && sleep_request |=> !drive_q)
		else $error("pins still driven during sleep");

	// Main scenarios worth seeing
	c_read_then_write: cover property (
		step && cmd_valid && cmd_read ##1 step && cmd_valid && !cmd_read);
	c_write_then_read: cover property (
		step && cmd_valid && !cmd_read ##1 step && cmd_valid && cmd_read);
	c_burst_wrap: cover property (
		step && load && sel ##1 (step && !load) [*4]);
	c_held_read: cover property (
		drive_q && !run ##1 drive_q);
	c_sleep_write: cover property (
		step && cmd_valid && !cmd_read ##1 run && sleep_request);
endmodule // ftsr_core

`default_nettype wire

// *** testbench/ftsr_ctl_model.sv ***
// Controller-side data bus model: late write data and the resolved data wire
`default_nettype none

module ftsr_ctl_model
	import ftsr_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        clock_hold_n,
	input  wire logic                        wr_req,
	input  wire logic [ftsr_pkg::WORD_W-1:0] wdata,
	input  wire logic [ftsr_pkg::WORD_W-1:0] dq_out,
	input  wire logic                        dq_oe,
	output logic      [ftsr_pkg::WORD_W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic              pend_q = 1'b0;
	logic              pend_d;
	logic [WORD_W-1:0] data_q, data_d;
	// Known start level so the released wire never floats unknown
	logic [WORD_W-1:0] last_q = '0;

	// Data goes out one unheld edge after its write command
	always_comb begin
		pend_d = clock_hold_n ? pend_q : wr_req;
		data_d = clock_hold_n ? data_q : wdata;
	end

	always_ff @(posedge clk) begin
		pend_q <= pend_d;
		data_q <= data_d;
		last_q <= dq_in;
	end

	// Released wire shows the inverse of its last level
	assign dq_in = dq_oe ? dq_out : (pend_q ? data_q : ~last_q);
endmodule // ftsr_ctl_model

`default_nettype wire

// *** testbench/flowthrough_late_write_sram_tb.sv ***
// Self-checking bench for the late-write burst SRAM core
`default_nettype none

module flowthrough_late_write_sram_tb;
	import ftsr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic        rw;
		logic [19:0] a;
		logic [1:0]  bw;
		logic [17:0] d;
	} ftsr_row_t;
	logic        clk = 1'b0, srst = 1'b1, clock_hold_n = 1'b0, chip_sel_b = 1'b1;
	logic        chip_sel_a_n = 1'b0, chip_sel_c_n = 1'b0, burst_wr = 1'b0;
	logic [2:0]  desel = 3'h0;
	logic        advance_or_load = 1'b1, read_write_n = 1'b1, output_enable_n = 1'b0;
	logic        linear_order_sel_n = 1'b1, sleep_request = 1'b0, dq_oe, wr_req = 1'b0;
	logic [19:0] addr = 20'h0;
	logic [1:0]  byte_lane_write_n = 2'h3;
	logic [17:0] wdata = 18'h0, dq_in, dq_out, e;
	int          n_mismatch = 0, compares = 0;
	ftsr_row_t   rows [14] = '{
		'{1'b0, 20'h10, 2'h0, 18'h3ffff}, '{1'b0, 20'h11, 2'h0, 18'h12345}, '{1'b1, 20'h10, 2'h0, 18'h3ffff},
		'{1'b0, 20'h10, 2'h2, 18'h00000}, '{1'b1, 20'h11, 2'h0, 18'h12345}, '{1'b1, 20'h10, 2'h0, 18'h3fe00},
		'{1'b0, 20'h13, 2'h0, 18'h0aaaa}, '{1'b1, 20'h13, 2'h0, 18'h0aaaa}, '{1'b0, 20'h10, 2'h3, 18'h00000},
		'{1'b1, 20'h10, 2'h0, 18'h3fe00}, '{1'b0, 20'h20, 2'h0, 18'h00100}, '{1'b0, 20'h21, 2'h0, 18'h00101},
		'{1'b0, 20'h22, 2'h0, 18'h00102}, '{1'b0, 20'h23, 2'h0, 18'h00103}};

	ftsr_core dut (.clk(clk), .srst(srst), .clock_hold_n(clock_hold_n), .chip_sel_a_n(chip_sel_a_n),
		.chip_sel_b(chip_sel_b), .chip_sel_c_n(chip_sel_c_n), .advance_or_load(advance_or_load),
		.read_write_n(read_write_n), .addr(addr), .byte_lane_write_n(byte_lane_write_n),
		.output_enable_n(output_enable_n), .linear_order_sel_n(linear_order_sel_n),
		.sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	ftsr_ctl_model ctl (.clk(clk), .clock_hold_n(clock_hold_n), .wr_req(wr_req), .wdata(wdata),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));

	// Free-running clock
	initial begin
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One bus cycle: drive at the falling edge, look just after the rising edge
	task automatic op(input logic adv, input logic rw, input logic [19:0] a, input logic [1:0] bw,
		input logic [17:0] d);
		@(negedge clk);
		clock_hold_n = 1'b0;
		chip_sel_a_n = desel[0];
		chip_sel_b = !desel[1];
		chip_sel_c_n = desel[2];
		advance_or_load = adv;
		read_write_n = rw;
		addr = a;
		byte_lane_write_n = bw;
		wdata = d;
		// Burst beats keep the direction chosen by their load
		if (!adv) begin
			burst_wr = ~rw;
		end
		wr_req = burst_wr;
		@(posedge clk);
		#1;
	endtask

	task automatic results();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#100us;
		n_mismatch++;
		results();
	end

	initial begin
		repeat (5) @(negedge clk);
		srst = 1'b0;
		chk({17'h0, dq_oe}, 18'h0);
		// Back-to-back table of reads and writes
		foreach (rows[i]) begin
			op(1'b0, rows[i].rw, rows[i].a, rows[i].bw, rows[i].d);
			if (rows[i].rw) begin
				chk(dq_out, rows[i].d);
				chk({17'h0, dq_oe}, 18'h1);
			end else begin
				chk({17'h0, dq_oe}, 18'h0);
			end
		end
		// Interleaved then linear bursts from 0x21, wrap on the fifth beat
		for (int o = 0; o < 2; o++) begin
			@(negedge clk);
			linear_order_sel_n = (o == 0);
			op(1'b0, 1'b1, 20'h21, 2'h3, 18'h0);
			chk(dq_out, 18'h101);
			for (int n = 1; n < 5; n++) begin
				op(1'b1, 1'b0, 20'h3, 2'h3, 18'h0);
				e = 18'h100 + ((o == 0) ? (18'h1 ^ 18'(n % 4)) : 18'((n + 1) % 4));
				chk(dq_out, e);
				if (n == 2 && o == 0) begin
					@(negedge clk);
					clock_hold_n = 1'b1;
					@(posedge clk);
					#1;
					chk(dq_out, e);
					chk({17'h0, dq_oe}, 18'h1);
				end
			end
		end
		linear_order_sel_n = 1'b1;
		// Two-beat burst write, then read back both words
		op(1'b0, 1'b0, 20'h30, 2'h0, 18'h00777);
		op(1'b1, 1'b1, 20'h0, 2'h0, 18'h00888);
		chk({17'h0, dq_oe}, 18'h0);
		op(1'b0, 1'b1, 20'h31, 2'h3, 18'h0);
		chk(dq_out, 18'h00888);
		op(1'b1, 1'b1, 20'h0, 2'h3, 18'h0);
		chk(dq_out, 18'h00777);
		// Each chip select alone ends a live read; the advance after it stays idle
		for (int s = 0; s < 3; s++) begin
			op(1'b0, 1'b1, 20'h11, 2'h3, 18'h0);
			chk({17'h0, dq_oe}, 18'h1);
			desel = 3'h1 << s;
			op(1'b0, 1'b1, 20'h10, 2'h3, 18'h0);
			chk({17'h0, dq_oe}, 18'h0);
			desel = 3'h0;
			op(1'b1, 1'b1, 20'h10, 2'h3, 18'h0);
			chk({17'h0, dq_oe}, 18'h0);
		end
		// Output enable acts without a clock edge
		op(1'b0, 1'b1, 20'h11, 2'h3, 18'h0);
		@(negedge clk);
		output_enable_n = 1'b1;
		#1;
		chk({17'h0, dq_oe}, 18'h0);
		@(negedge clk);
		output_enable_n = 1'b0;
		#1;
		chk({17'h0, dq_oe}, 18'h1);
		// Sleep keeps data and ignores commands
		@(negedge clk);
		sleep_request = 1'b1;
		op(1'b0, 1'b1, 20'h13, 2'h3, 18'h0);
		chk({17'h0, dq_oe}, 18'h0);
		@(negedge clk);
		sleep_request = 1'b0;
		op(1'b0, 1'b1, 20'h10, 2'h3, 18'h0);
		chk(dq_out, 18'h3fe00);
		// Mid-run reset drops the drive; a load on the first edge after release works
		@(negedge clk);
		srst = 1'b1;
		@(posedge clk);
		#1;
		chk({17'h0, dq_oe}, 18'h0);
		@(negedge clk);
		srst = 1'b0;
		@(posedge clk);
		#1;
		chk(dq_out, 18'h3fe00);
		chk({17'h0, dq_oe}, 18'h1);
		results();
	end
endmodule // flowthrough_late_write_sram_tb

`default_nettype wire
